/* File: design/wit_params.svh */
// Constants for the watchdog / interval timer: offsets, fields, resets.
// Assumes inclusion by bare name from the design and bench files.
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH
`define WIT_PERIOD_SEL_ADDR 16'hff42
`define WIT_MODE_CTRL_ADDR 16'hfff9
`define WIT_PERIOD_SEL_RESET 8'h00
`define WIT_MODE_CTRL_RESET 8'h00
`define WIT_RUN_BIT 7
`define WIT_WDOG_SEL_BIT 4
`define WIT_ACTION_BIT 3
`define WIT_MODE_WMASK 8'h98
`define WIT_SEL_WMASK 8'h07
`define WIT_CNT_W 20
`define WIT_PRE_W 4
`define WIT_PRE_MAX 4'hf
// Host-side register map of the controller
`define WIT_H_CTRL 4'h0
`define WIT_H_STATUS 4'h1
`define WIT_H_MASK 4'h2
`define WIT_H_READ 4'h3
`define WIT_H_CAPT 4'h4
`define WIT_H_OP 4'h5
`define WIT_EV_IRQ 0
`define WIT_EV_NMI 1
`define WIT_EV_RST 2
`define WIT_EV_DONE 3
`endif

/* File: design/wit_pkg.sv */
// Types shared by both ends of the watchdog / interval timer link.
// Assumes nothing beyond a SystemVerilog compiler.
package wit_pkg;
  typedef enum logic [1:0] {
    WIT_MODE_INTERVAL = 2'h0,
    WIT_MODE_NMI = 2'h1,
    WIT_MODE_RESET = 2'h2
  } wit_mode_t;
  typedef enum logic [2:0] {
    WIT_ST_IDLE = 3'h1,
    WIT_ST_ACCESS = 3'h2,
    WIT_ST_DONE = 3'h4
  } wit_state_t;
endpackage : wit_pkg

/* File: design/wit_if.sv */
// Link between the timer and its CPU-side partner: byte bus plus events.
// Assumes one clock and one reset shared by both ends.
`timescale 1ns/1ps
interface wit_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic wr_bit;
  logic [2:0] bit_sel;
  logic rd;
  logic [7:0] rdata;
  logic interval_irq;
  logic interval_irq_mask;
  logic interval_irq_priority;
  logic irq_req;
  logic nmi_req;
  logic sys_reset_req;
  logic halt_mode;
  logic stop_mode;
  logic sub_clk_cpu;
  modport timer (
    input addr, wdata, wr, wr_bit, bit_sel, rd,
    input interval_irq_mask, interval_irq_priority,
    input halt_mode, stop_mode, sub_clk_cpu,
    output rdata, interval_irq, irq_req, nmi_req, sys_reset_req
  );
  modport cpu (
    output addr, wdata, wr, wr_bit, bit_sel, rd,
    output interval_irq_mask, interval_irq_priority,
    output halt_mode, stop_mode, sub_clk_cpu,
    input rdata, interval_irq, irq_req, nmi_req, sys_reset_req
  );
endinterface : wit_if

/* File: design/wit_timer.sv */
// Watchdog / interval timer: two byte registers, divider, overflow actions.
// Assumes the partner drives the link synchronously on the same clock.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "wit_params.svh"
module wit_timer (
  input wire logic clk,
  input wire logic rst_n,
  wit_if.timer bus
);
  logic [7:0] period_select_reg;
  logic [7:0] mode_control_reg;
  logic [`WIT_PRE_W-1:0] prescale;
  logic [`WIT_CNT_W-1:0] count;
  logic [`WIT_CNT_W-1:0] next_count;
  logic run;
  logic watchdog_select_bit;
  logic overflow_action_bit;
  logic counting;
  logic overflow;
  logic run_strobe;
  logic [7:0] mode_wdata;
  logic [4:0] top_bit;
  logic [4:0] carry_pos;
  logic [`WIT_CNT_W-1:0] low_ones;
  logic mode_wr;
  logic period_wr;
  logic mode_rd;
  logic period_rd;
  wit_pkg::wit_mode_t mode;

  assign run = mode_control_reg[`WIT_RUN_BIT];
  assign watchdog_select_bit = mode_control_reg[`WIT_WDOG_SEL_BIT];
  assign overflow_action_bit = mode_control_reg[`WIT_ACTION_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Mode register takes byte and single-bit writes alike
  assign mode_wr = (bus.wr || bus.wr_bit) && bus.addr == `WIT_MODE_CTRL_ADDR;
  // A single-bit write to the period register is dropped
  assign period_wr = bus.wr && bus.addr == `WIT_PERIOD_SEL_ADDR;
  assign mode_rd = bus.rd && bus.addr == `WIT_MODE_CTRL_ADDR;
  assign period_rd = bus.rd && bus.addr == `WIT_PERIOD_SEL_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_comb
  begin
    mode_wdata = bus.wdata;
    if (bus.wr_bit)
    begin
      mode_wdata = mode_control_reg;
      mode_wdata[bus.bit_sel] = bus.wdata[0];
    end
  end

  assign run_strobe = mode_wr && mode_wdata[`WIT_RUN_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_control_reg <= `WIT_MODE_CTRL_RESET;
    else if (mode_wr)
      // OR-in only: software can set but never clear
      mode_control_reg <= mode_control_reg | (mode_wdata & `WIT_MODE_WMASK);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      period_select_reg <= `WIT_PERIOD_SEL_RESET;
    else if (period_wr)
      period_select_reg <= bus.wdata & `WIT_SEL_WMASK;
  end

  // Idle and unmapped cycles return zero, never stale data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.rdata <= 8'h00;
    else if (mode_rd)
      bus.rdata <= mode_control_reg;
    else if (period_rd)
      bus.rdata <= period_select_reg;
    else
      bus.rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider
  // Code 7 skips one stage, so its period is four times code 6
  // Halt does not matter; stop and subsystem clock freeze it
  assign counting = run && !bus.stop_mode && !bus.sub_clk_cpu;

  // Free-running prescaler is never cleared, so the first period after a
  // restart runs up to 15 clocks short, well under 0.5%
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= '0;
    else if (counting)
      prescale <= prescale + `WIT_PRE_W'(1);
  end

  always_comb
  begin
    case (period_select_reg[2:0])
      3'h0: top_bit = 5'h0b;
      3'h1: top_bit = 5'h0c;
      3'h2: top_bit = 5'h0d;
      3'h3: top_bit = 5'h0e;
      3'h4: top_bit = 5'h0f;
      3'h5: top_bit = 5'h10;
      3'h6: top_bit = 5'h11;
      3'h7: top_bit = 5'h13;
      default: top_bit = 5'h0b;
    endcase
  end

  assign next_count = count + `WIT_CNT_W'(1);
  // The prescaler supplies the four lowest divider stages
  assign carry_pos = top_bit - 5'h04;

  // Bits above the carry position count as ones, so a stale high count
  // left by a period change still reaches a carry instead of wrapping
  genvar gi;
  generate
    for (gi = 0; gi < `WIT_CNT_W; gi = gi + 1)
    begin : g_low_ones
      assign low_ones[gi] = (5'(gi) > carry_pos) || count[gi];
    end
  endgenerate

  // Carry out of the selected bit
  assign overflow = counting && prescale == `WIT_PRE_MAX && &low_ones &&
    !run_strobe;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (run_strobe)
      count <= '0;
    else if (overflow)
      count <= '0;
    else if (counting && prescale == `WIT_PRE_MAX)
      count <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow actions
  always_comb
  begin
    if (!watchdog_select_bit)
      mode = wit_pkg::WIT_MODE_INTERVAL;
    else if (!overflow_action_bit)
      mode = wit_pkg::WIT_MODE_NMI;
    else
      mode = wit_pkg::WIT_MODE_RESET;
  end

  // Nothing here enforces the restart deadline; the overflow is the alarm
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.interval_irq <= 1'b0;
    else
      bus.interval_irq <= overflow && mode == wit_pkg::WIT_MODE_INTERVAL;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.nmi_req <= 1'b0;
    else
      bus.nmi_req <= overflow && mode == wit_pkg::WIT_MODE_NMI;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.sys_reset_req <= 1'b0;
    else
      bus.sys_reset_req <=
        overflow && mode == wit_pkg::WIT_MODE_RESET;
  end

  // Highest maskable source; the priority flag input is not used here
  assign bus.irq_req =
    bus.interval_irq && !bus.interval_irq_mask;
endmodule : wit_timer

/* File: design/wit_cpu.sv */
// CPU-side end: software ports reach timer registers and event status.
// Assumes software uses the plain strobe port; reads answer next cycle.
`timescale 1ns/1ps
`include "wit_params.svh"
module wit_cpu (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  output logic irq,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic sub_clk_cpu,
  wit_if.cpu bus
);
  logic [3:0] status;
  logic [3:0] mask;
  logic [7:0] capt;
  logic [3:0] events;
  logic op_go;
  wit_pkg::wit_state_t state;

  assign op_go = sw_wr && sw_addr == `WIT_H_OP &&
    state == wit_pkg::WIT_ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer: OP word = {kind[1:0], unused, reg_sel, unused, bitpos[2:0], data[7:0]}
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= wit_pkg::WIT_ST_IDLE;
    else
      case (state)
        wit_pkg::WIT_ST_IDLE: if (op_go) state <= wit_pkg::WIT_ST_ACCESS;
        wit_pkg::WIT_ST_ACCESS: state <= wit_pkg::WIT_ST_DONE;
        wit_pkg::WIT_ST_DONE: state <= wit_pkg::WIT_ST_IDLE;
        default: state <= wit_pkg::WIT_ST_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus.addr <= 16'h0000;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.wr_bit <= 1'b0;
      bus.bit_sel <= 3'h0;
      bus.rd <= 1'b0;
    end
    else
    begin
      bus.wr <= op_go && sw_wdata[15:14] == 2'h1;
      bus.wr_bit <= op_go && sw_wdata[15:14] == 2'h2 && !sw_wdata[12];
      bus.rd <= op_go && sw_wdata[15:14] == 2'h3;
      if (op_go)
      begin
        bus.addr <= sw_wdata[12] ? `WIT_PERIOD_SEL_ADDR :
          `WIT_MODE_CTRL_ADDR;
        bus.bit_sel <= sw_wdata[10:8];
        bus.wdata <= sw_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      capt <= 8'h00;
    else if (state == wit_pkg::WIT_ST_DONE)
      capt <= bus.rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control pins and interrupt status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus.interval_irq_mask <= 1'b1;
      bus.interval_irq_priority <= 1'b1;
    end
    else if (sw_wr && sw_addr == `WIT_H_CTRL)
    begin
      bus.interval_irq_mask <= sw_wdata[0];
      bus.interval_irq_priority <= sw_wdata[1];
    end
  end

  assign bus.halt_mode = halt_mode;
  assign bus.stop_mode = stop_mode;
  assign bus.sub_clk_cpu = sub_clk_cpu;

  assign events = {state == wit_pkg::WIT_ST_DONE, bus.sys_reset_req,
    bus.nmi_req, bus.irq_req};

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status <= 4'h0;
    else if (sw_wr && sw_addr == `WIT_H_STATUS)
      status <= (status & ~sw_wdata[3:0]) | events;
    else
      status <= status | events;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask <= 4'h0;
    else if (sw_wr && sw_addr == `WIT_H_MASK)
      mask <= sw_wdata[3:0];
  end

  assign irq = |(status & mask);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_rdata <= 16'h0000;
    else if (sw_rd)
      case (sw_addr)
        `WIT_H_CTRL: sw_rdata <= {14'h0000, bus.interval_irq_priority,
          bus.interval_irq_mask};
        `WIT_H_STATUS: sw_rdata <= {12'h000, status};
        `WIT_H_MASK: sw_rdata <= {12'h000, mask};
        `WIT_H_READ: sw_rdata <= {15'h0000, state != wit_pkg::WIT_ST_IDLE};
        `WIT_H_CAPT: sw_rdata <= {8'h00, capt};
        default: sw_rdata <= 16'h0000;
      endcase
    else
      sw_rdata <= 16'h0000;
  end
endmodule : wit_cpu

/* File: verif/wit_checker.sv */
// Checker of the timer link: event pulses, gating, frozen counting.
// Assumes the link signals of the single clock domain as plain inputs.
`timescale 1ns/1ps
`include "wit_params.svh"
module wit_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic wr_bit,
  input wire logic [2:0] bit_sel,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic interval_irq,
  input wire logic interval_irq_mask,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic sys_reset_req,
  input wire logic stop_mode,
  input wire logic sub_clk_cpu
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [12:0] gap;
  logic run_wr;
  logic any_ev;
  assign any_ev = interval_irq || nmi_req || sys_reset_req;
  assign run_wr = addr == `WIT_MODE_CTRL_ADDR &&
    ((wr && wdata[7]) || (wr_bit && bit_sel == 3'h7 && wdata[0]));
  ////////////////////////////////////////////////////////////////////////
  // Cycles since restart or event; saturates so long stops stay legal
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gap <= 13'h0000;
    else if (run_wr || any_ev)
      gap <= 13'h0000;
    else if (gap != 13'h1fff)
      gap <= gap + 13'h0001;
  end
  ////////////////////////////////////////////////////////////////////////
  a_irq_gate: assert property (
    irq_req == (interval_irq && !interval_irq_mask))
    else $error("maskable request not gated by its mask");
  a_irq_pulse: assert property (interval_irq |=> !interval_irq [*8])
    else $error("interval pulse too long");
  a_nmi_pulse: assert property (nmi_req |=> !nmi_req [*8])
    else $error("non-maskable pulse too long");
  a_rst_pulse: assert property (
    sys_reset_req |=> !sys_reset_req [*8])
    else $error("reset pulse too long");
  a_one_action: assert property (
    $onehot0({interval_irq, nmi_req, sys_reset_req}))
    else $error("more than one overflow action");
  a_stop_freeze: assert property (
    stop_mode && $past(stop_mode) && $past(stop_mode, 2) |-> !any_ev)
    else $error("overflow while stopped");
  a_sub_freeze: assert property (
    sub_clk_cpu && $past(sub_clk_cpu) && $past(sub_clk_cpu, 2) |-> !any_ev)
    else $error("overflow on subsystem clock");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_period_min: assert property (any_ev |-> gap >= 13'h0fec)
    else $error("overflow sooner than shortest period");
  c_irq: cover property (irq_req);
  c_nmi: cover property (nmi_req);
  c_rst: cover property (sys_reset_req);
  c_restart: cover property (run_wr && gap > 13'h0800);
endmodule : wit_checker

/* File: verif/watchdog_interval_timer_tb.sv */
// Testbench: software port drives the CPU end, which drives the timer.
// Assumes the CPU end's op/status map; period code 0 keeps runs short.
`timescale 1ns/1ps
`include "wit_params.svh"
module watchdog_interval_timer_tb;
  logic clk;
  logic rst_n;
  logic [3:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [15:0] sw_rdata;
  logic irq;
  logic halt_mode;
  logic stop_mode;
  logic sub_clk_cpu;
  int error_cnt;
  int num_checks;
  wit_if bus_if();
  wit_timer wit_timer_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if));
  wit_cpu wit_cpu_inst (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .irq(irq), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .sub_clk_cpu(sub_clk_cpu), .bus(bus_if));
  wit_checker wit_checker_inst (.clk(clk), .rst_n(rst_n),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .wr_bit(bus_if.wr_bit), .bit_sel(bus_if.bit_sel), .rd(bus_if.rd),
    .rdata(bus_if.rdata), .interval_irq(bus_if.interval_irq),
    .interval_irq_mask(bus_if.interval_irq_mask), .irq_req(bus_if.irq_req),
    .nmi_req(bus_if.nmi_req), .sys_reset_req(bus_if.sys_reset_req),
    .stop_mode(bus_if.stop_mode), .sub_clk_cpu(bus_if.sub_clk_cpu));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [15:0] s,
    input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(posedge clk);
    d = sw_rdata;
  endtask : sw_read
  // Kind 1 byte write, 2 bit write, 3 read; sel 1 is the period register
  task automatic op(input logic [1:0] k, input logic sel,
    input logic [2:0] b, input logic [7:0] d);
    sw_write(`WIT_H_OP, {k, 1'b0, sel, 1'b0, b, d});
    repeat (4) @(posedge clk);
  endtask : op
  task automatic reg_chk(input string n, input logic sel,
    input logic [7:0] e);
    logic [15:0] v;
    op(2'h3, sel, 3'h0, 8'h00);
    sw_read(`WIT_H_CAPT, v);
    check(n, v, {8'h00, e});
  endtask : reg_chk
  task automatic st_chk(input string n, input int w, input logic [15:0] e);
    logic [15:0] v;
    repeat (w) @(posedge clk);
    sw_read(`WIT_H_STATUS, v);
    check(n, v & 16'h0007, e);
  endtask : st_chk
  // Restart by setting the run bit alone, then clear stale events
  task automatic restart();
    op(2'h2, 1'b0, 3'h7, 8'h01);
    sw_write(`WIT_H_STATUS, 16'h000f);
  endtask : restart
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("BAD watchdog expected end seen hang");
    end_sim();
  end
  initial
  begin
    rst_n = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    halt_mode = 1'b0;
    stop_mode = 1'b0;
    sub_clk_cpu = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reg_chk("period", 1'b1, 8'h00);
    reg_chk("mode", 1'b0, 8'h00);
    op(2'h1, 1'b1, 3'h0, 8'hff);
    reg_chk("period", 1'b1, 8'h07);
    op(2'h1, 1'b1, 3'h0, 8'h00);
    op(2'h2, 1'b1, 3'h0, 8'h01);
    reg_chk("period", 1'b1, 8'h00);
    $display("test registers done");
    sw_write(`WIT_H_CTRL, 16'h0000);
    sw_write(`WIT_H_MASK, 16'h0001);
    restart();
    st_chk("early", 4040, 16'h0000);
    st_chk("interval", 100, 16'h0001);
    check("irq", {15'h0000, irq}, 16'h0001);
    sw_write(`WIT_H_MASK, 16'h0000);
    @(posedge clk);
    check("irq", {15'h0000, irq}, 16'h0000);
    sw_write(`WIT_H_MASK, 16'h0001);
    sw_write(`WIT_H_STATUS, 16'h000f);
    st_chk("repeat", 4096, 16'h0001);
    restart();
    repeat (3)
    begin
      repeat (3000) @(posedge clk);
      op(2'h2, 1'b0, 3'h7, 8'h01);
    end
    st_chk("restart", 0, 16'h0000);
    $display("test interval done");
    restart();
    stop_mode <= 1'b1;
    st_chk("stop", 6000, 16'h0000);
    stop_mode <= 1'b0;
    sub_clk_cpu <= 1'b1;
    st_chk("subclk", 6000, 16'h0000);
    sub_clk_cpu <= 1'b0;
    halt_mode <= 1'b1;
    restart();
    st_chk("halt", 4150, 16'h0001);
    halt_mode <= 1'b0;
    sw_write(`WIT_H_CTRL, 16'h0001);
    restart();
    st_chk("masked", 4150, 16'h0000);
    sw_write(`WIT_H_CTRL, 16'h0000);
    $display("test freeze done");
    // Period stays at code 0 while the run bit keeps the timer going
    op(2'h1, 1'b0, 3'h0, 8'h90);
    sw_write(`WIT_H_STATUS, 16'h000f);
    st_chk("nmi", 4150, 16'h0002);
    op(2'h1, 1'b0, 3'h0, 8'h00);
    reg_chk("mode", 1'b0, 8'h90);
    op(2'h2, 1'b0, 3'h3, 8'h01);
    restart();
    st_chk("sysreset", 4150, 16'h0004);
    $display("test watchdog done");
    // Only reset clears the run bit, so the period changes after one
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_chk("mode", 1'b0, 8'h00);
    sw_write(`WIT_H_CTRL, 16'h0000);
    op(2'h1, 1'b1, 3'h0, 8'h01);
    restart();
    st_chk("code1", 8100, 16'h0000);
    st_chk("code1", 150, 16'h0001);
    $display("test period done");
    end_sim();
  end
endmodule : watchdog_interval_timer_tb
